// >>> slw_far_model.sv
`timescale 1ns/10ps
module slw_far_model (
  input wire logic clk,
  output slw_pkg::slw_sym_s start_a,
  output slw_pkg::slw_sym_s start_b,
  output slw_pkg::slw_sym_s stop_a,
  output slw_pkg::slw_sym_s stop_b,
  output logic bit_tick
);
  slw_pkg::slw_sym_s s[4] = '{default: '0};
  slw_pkg::slw_sym_s q[4][$];
  int gap = 1;
  int gcnt = 0;
  logic tick_q = 1'h1;

  // One serial bit every gap clocks, a supported rate
  assign bit_tick = tick_q;

  // Serial bit pacing
  always @(posedge clk) begin
    gcnt <= gcnt + 1;
    tick_q <= (gcnt % gap) == 0;
  end
  assign start_a = s[0];
  assign start_b = s[1];
  assign stop_a = s[2];
  assign stop_b = s[3];

  // Queued symbols first, else random traffic with no monitored comma
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      slw_pkg::slw_sym_s x;
      x = 10'($urandom);
      if (x.valid && x.ctrl && x.data inside {slw_pkg::K28_1,
          slw_pkg::K28_5, slw_pkg::K28_7}) x.ctrl = 1'h0;
      if (q[i].size() > 0) x = q[i].pop_front();
      s[i] <= x;
    end
  end

  // Queue one control symbol at a point for the next edge
  task automatic send(input int pt, input logic [7:0] d);
    @(negedge clk);
    q[pt].push_back('{1'h1, 1'h1, d});
    @(posedge clk);
  endtask
endmodule

// >>> slw_meas_clk.sv
`timescale 1ns/10ps
module slw_meas_clk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_tick,
  input wire slw_pkg::slw_rate_e rate_mode,
  input wire logic [1:0] div_sel,
  input wire logic byte_src,
  output logic meas_tick
);

  logic [4:0] rate_cnt_q;
  logic [4:0] user_cnt_q;
  logic [4:0] byte_cnt_q;
  logic [4:0] rate_tc;
  logic [4:0] user_tc;
  logic hs_tick;
  logic hs_div_tick;
  logic byte_tick;

  // --------------------------------------------------------------
  // Divide selection
  // --------------------------------------------------------------
  // Bit-rate divisor follows the serializer rate mode
  always_comb begin
    unique case (rate_mode)
      slw_pkg::RATE_FULL: rate_tc = slw_pkg::RATE_FULL_TC;
      slw_pkg::RATE_HALF: rate_tc = slw_pkg::RATE_HALF_TC;
      slw_pkg::RATE_QUARTER: rate_tc = slw_pkg::RATE_QUARTER_TC;
      slw_pkg::RATE_EIGHTH: rate_tc = slw_pkg::RATE_EIGHTH_TC;
    endcase
  end

  // User post-divider 1, 2, 4 or 8
  always_comb begin
    unique case (div_sel)
      2'h0: user_tc = slw_pkg::USER_DIV1_TC;
      2'h1: user_tc = slw_pkg::USER_DIV2_TC;
      2'h2: user_tc = slw_pkg::USER_DIV4_TC;
      2'h3: user_tc = slw_pkg::USER_DIV8_TC;
    endcase
  end

  assign hs_tick = bit_tick && (rate_cnt_q >= rate_tc);
  assign hs_div_tick = hs_tick && (user_cnt_q >= user_tc);
  assign byte_tick = bit_tick && (byte_cnt_q >= slw_pkg::BYTE_TC);

  // --------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------
  // Rate-mode prescaler on serial bit ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt_q <= slw_pkg::DIV_ZERO;
    end else if (hs_tick) begin
      rate_cnt_q <= slw_pkg::DIV_ZERO;
    end else if (bit_tick) begin
      rate_cnt_q <= rate_cnt_q + slw_pkg::DIV_ONE;
    end
  end

  // User divider on the high speed measurement clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      user_cnt_q <= slw_pkg::DIV_ZERO;
    end else if (hs_div_tick) begin
      user_cnt_q <= slw_pkg::DIV_ZERO;
    end else if (hs_tick) begin
      user_cnt_q <= user_cnt_q + slw_pkg::DIV_ONE;
    end
  end

  // Recovered byte clock, one tick per twenty bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_q <= slw_pkg::DIV_ZERO;
    end else if (byte_tick) begin
      byte_cnt_q <= slw_pkg::DIV_ZERO;
    end else if (bit_tick) begin
      byte_cnt_q <= byte_cnt_q + slw_pkg::DIV_ONE;
    end
  end

  // Registered measurement tick from the chosen source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_tick <= 1'h0;
    end else begin
      meas_tick <= byte_src ? byte_tick : hs_div_tick;
    end
  end

endmodule

// >>> slw_pkg.sv
package slw_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;

  // Control field positions
  localparam int START_SEL_BIT = 0;
  localparam int STOP_SEL_BIT = 1;
  localparam int MANUAL_EN_BIT = 2;
  localparam int BYTE_SRC_BIT = 3;
  localparam int RATE_LSB = 4;
  localparam int DIV_LSB = 6;
  localparam int ENABLE_BIT = 8;
  localparam logic [8:0] CTRL_RST = 9'h100;

  // Status field positions
  localparam int ST_IDLE_BIT = 0;
  localparam int ST_RUN_BIT = 1;
  localparam int ST_HOLD_BIT = 2;
  localparam int ST_PIN_BIT = 3;
  localparam int ST_SAT_BIT = 4;

  // ---------------------------------------------------------------
  // Comma characters and counter range
  // ---------------------------------------------------------------
  localparam logic [7:0] K28_1 = 8'h3C;
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [7:0] K28_7 = 8'hFC;
  localparam int CNT_W = 20;
  localparam logic [19:0] CNT_MAX = 20'hF_FFFF;
  localparam logic [19:0] CNT_ZERO = 20'h0_0000;
  localparam logic [19:0] CNT_ONE = 20'h0_0001;

  // ---------------------------------------------------------------
  // Measurement clock dividers (terminal counts, value minus one)
  // ---------------------------------------------------------------
  localparam int DIV_W = 5;
  localparam logic [4:0] RATE_FULL_TC = 5'h07;
  localparam logic [4:0] RATE_HALF_TC = 5'h03;
  localparam logic [4:0] RATE_QUARTER_TC = 5'h01;
  localparam logic [4:0] RATE_EIGHTH_TC = 5'h00;
  localparam logic [4:0] USER_DIV1_TC = 5'h00;
  localparam logic [4:0] USER_DIV2_TC = 5'h01;
  localparam logic [4:0] USER_DIV4_TC = 5'h03;
  localparam logic [4:0] USER_DIV8_TC = 5'h07;
  localparam logic [4:0] BYTE_TC = 5'h13;
  localparam logic [4:0] DIV_ZERO = 5'h00;
  localparam logic [4:0] DIV_ONE = 5'h01;

  // Serializer rate modes
  typedef enum logic [1:0] {
    RATE_FULL = 2'h0,
    RATE_HALF = 2'h1,
    RATE_QUARTER = 2'h2,
    RATE_EIGHTH = 2'h3
  } slw_rate_e;

  // One symbol observed at a datapath monitor point
  typedef struct packed {
    logic valid;
    logic ctrl;
    logic [7:0] data;
  } slw_sym_s;

endpackage

// >>> slw_stopwatch.sv
// Function
// - Two start and two stop points, selectable.
// - Time from start comma to stop comma.
// - Commas are K28.1, K28.5, K28.7 only.
// - First start comma starts; later ones ignored.
// - First stop comma halts and freezes count.
// - Result is 20 bits, readable by management.
// - Overrange result saturates at 0xFFFFF.
// - One result kept until management reads it.
// - Never started means result reads zero.
// - Optional manual start/stop from pin level.
// - Full rate: bit rate divided by 8.
// - Half /4, quarter /2, eighth /1.
// - Register divides measurement clock by 1/2/4/8 (here only the rate-mode clock; the byte clock is not divided).
// - Alternative source: recovered byte clock, bit/20.
// - Count accurate to one measurement clock period.
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/10ps
module slw_stopwatch (
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Datapath monitor points
  input wire slw_pkg::slw_sym_s start_pt_a,
  input wire slw_pkg::slw_sym_s start_pt_b,
  input wire slw_pkg::slw_sym_s stop_pt_a,
  input wire slw_pkg::slw_sym_s stop_pt_b,
  // Serial bit time tick from the serializer
  input wire logic bit_tick,
  // Manual start/stop pin, asynchronous
  input wire logic manual_stopwatch_pin
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SLW_ARMED = 3'b001,
    SLW_RUN = 3'b010,
    SLW_HOLD = 3'b100
  } slw_state_e;

  slw_state_e state_q;
  slw_state_e state_d;
  logic [8:0] ctrl_q;
  logic [19:0] cnt_q;
  logic [19:0] result_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic meas_tick;
  logic [1:0] start_hit;
  logic [1:0] stop_hit;
  logic start_ev;
  logic stop_ev;
  logic manual_rise;
  logic manual_fall;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic result_rd;
  logic release_ev;
  logic saturated;
  slw_pkg::slw_sym_s start_pts [2];
  slw_pkg::slw_sym_s stop_pts [2];

  // ---------------------------------------------------------------
  // Measurement clock generation
  // ---------------------------------------------------------------
  // Tick generator covers rate mode, user divide and byte clock
  slw_meas_clk u_meas_clk (
    .clk(clk),
    .rst_n(rst_n),
    .bit_tick(bit_tick),
    .rate_mode(slw_pkg::slw_rate_e'(ctrl_q[slw_pkg::RATE_LSB +: 2])),
    .div_sel(ctrl_q[slw_pkg::DIV_LSB +: 2]),
    .byte_src(ctrl_q[slw_pkg::BYTE_SRC_BIT]),
    .meas_tick(meas_tick)
  );

  // ---------------------------------------------------------------
  // Comma detection
  // ---------------------------------------------------------------
  // Gather the monitor points into small arrays
  assign start_pts[0] = start_pt_a;
  assign start_pts[1] = start_pt_b;
  assign stop_pts[0] = stop_pt_a;
  assign stop_pts[1] = stop_pt_b;

  // Per-point comma match against the three monitored characters
  for (genvar i = 0; i < 2; i++) begin : g_pt
    assign start_hit[i] = start_pts[i].valid && start_pts[i].ctrl &&
      (start_pts[i].data == slw_pkg::K28_1 ||
       start_pts[i].data == slw_pkg::K28_5 ||
       start_pts[i].data == slw_pkg::K28_7);
    assign stop_hit[i] = stop_pts[i].valid && stop_pts[i].ctrl &&
      (stop_pts[i].data == slw_pkg::K28_1 ||
       stop_pts[i].data == slw_pkg::K28_5 ||
       stop_pts[i].data == slw_pkg::K28_7);
  end

  // ---------------------------------------------------------------
  // Manual pin synchroniser
  // ---------------------------------------------------------------
  // Two flops, then a delayed copy for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 1'h0;
      pin_sync_q <= 1'h0;
      pin_prev_q <= 1'h0;
    end else begin
      pin_meta_q <= manual_stopwatch_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign manual_rise = pin_sync_q && !pin_prev_q;
  assign manual_fall = !pin_sync_q && pin_prev_q;

  // Start and stop events from the chosen source
  always_comb begin
    if (!ctrl_q[slw_pkg::ENABLE_BIT]) begin
      start_ev = 1'h0;
      stop_ev = 1'h0;
    end else if (ctrl_q[slw_pkg::MANUAL_EN_BIT]) begin
      start_ev = manual_rise;
      stop_ev = manual_fall;
    end else begin
      start_ev = start_hit[ctrl_q[slw_pkg::START_SEL_BIT]];
      stop_ev = stop_hit[ctrl_q[slw_pkg::STOP_SEL_BIT]];
    end
  end

  // ---------------------------------------------------------------
  // Wishbone decode
  // ---------------------------------------------------------------
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;
  assign bus_rd = bus_req && !wb_we_i;
  assign result_rd = bus_rd && (wb_adr_i == slw_pkg::RESULT_OFS);
  assign release_ev = result_rd && (state_q == SLW_HOLD);
  assign saturated = (result_q == slw_pkg::CNT_MAX);

  // Acknowledge one cycle after the request is seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'h0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Control register, byte lane 0 and lane 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= slw_pkg::CTRL_RST;
    end else if (bus_wr && wb_adr_i == slw_pkg::CTRL_OFS) begin
      if (wb_sel_i[0]) begin
        ctrl_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl_q[slw_pkg::ENABLE_BIT] <= wb_dat_i[slw_pkg::ENABLE_BIT];
      end
    end
  end

  // Read data mux, registered with the acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_rd) begin
      unique case (wb_adr_i)
        slw_pkg::CTRL_OFS: begin
          wb_dat_o <= {23'h00_0000, ctrl_q};
        end
        slw_pkg::STATUS_OFS: begin
          wb_dat_o <= {27'h000_0000, saturated, pin_sync_q,
                       state_q == SLW_HOLD, state_q == SLW_RUN,
                       state_q == SLW_ARMED};
        end
        slw_pkg::RESULT_OFS: begin
          wb_dat_o <= {12'h000, result_q};
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Stopwatch sequencer
  // ---------------------------------------------------------------
  // Armed waits for a start, run waits for a stop, hold waits
  // for the result read
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SLW_ARMED: begin
        if (start_ev) begin
          state_d = SLW_RUN;
        end
      end
      SLW_RUN: begin
        if (stop_ev) begin
          state_d = SLW_HOLD;
        end
      end
      SLW_HOLD: begin
        if (release_ev) begin
          // A start in the release cycle is not lost
          state_d = start_ev ? SLW_RUN : SLW_ARMED;
        end
      end
      default: begin
        state_d = SLW_ARMED;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SLW_ARMED;
    end else begin
      state_q <= state_d;
    end
  end

  // Elapsed counter, cleared on start, saturating while running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= slw_pkg::CNT_ZERO;
    end else if (state_q != SLW_RUN && state_d == SLW_RUN) begin
      cnt_q <= slw_pkg::CNT_ZERO;
    end else if (state_q == SLW_RUN && meas_tick) begin
      if (cnt_q != slw_pkg::CNT_MAX) begin
        cnt_q <= cnt_q + slw_pkg::CNT_ONE;
      end
    end
  end

  // Held result, written once per measurement
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= slw_pkg::CNT_ZERO;
    end else if (state_q == SLW_RUN && stop_ev) begin
      // Count reaches the result whole, in one edge
      result_q <= cnt_q;
    end else if (release_ev) begin
      result_q <= slw_pkg::CNT_ZERO;
    end
  end

endmodule

// >>> slw_stopwatch_chk.sv
`timescale 1ns/10ps
module slw_stopwatch_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire slw_pkg::slw_sym_s start_pt_a,
  input wire slw_pkg::slw_sym_s start_pt_b,
  input wire slw_pkg::slw_sym_s stop_pt_a,
  input wire slw_pkg::slw_sym_s stop_pt_b,
  input wire logic bit_tick,
  input wire logic manual_stopwatch_pin
);
  logic take;
  logic rd;
  logic [8:0] ctrl_q;
  logic [2:0] pin_st_q;
  logic pin_d_q;
  logic seen_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Request taken, read being answered
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd = wb_ack_o && !wb_we_i;

  // Monitored comma test
  function automatic logic comma(input slw_pkg::slw_sym_s s);
    return s.valid && s.ctrl && (s.data == slw_pkg::K28_1 ||
      s.data == slw_pkg::K28_5 || s.data == slw_pkg::K28_7);
  endfunction

  // Mirror of the control word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= slw_pkg::CTRL_RST;
    end else if (take && wb_we_i && wb_adr_i == slw_pkg::CTRL_OFS) begin
      if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) ctrl_q[8] <= wb_dat_i[8];
    end
  end

  // Pin stability count and any start evidence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_d_q <= 1'h0;
      pin_st_q <= 3'h0;
      seen_q <= 1'h0;
    end else begin
      pin_d_q <= manual_stopwatch_pin;
      pin_st_q <= (manual_stopwatch_pin != pin_d_q) ? 3'h0 :
        (pin_st_q == 3'h7) ? 3'h7 : pin_st_q + 3'h1;
      if (comma(start_pt_a) || comma(start_pt_b) || manual_stopwatch_pin)
        seen_q <= 1'h1;
    end
  end

  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_answer: assert property (take |=> wb_ack_o)
    else $error("request not answered in the next cycle");
  chk_data_idle: assert property (
    !rd |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside a read");
  chk_result_width: assert property (
    rd && wb_adr_i == slw_pkg::RESULT_OFS |-> wb_dat_o[31:20] == 12'h0)
    else $error("result wider than twenty bits");
  chk_state_onehot: assert property (
    rd && wb_adr_i == slw_pkg::STATUS_OFS |-> $onehot(wb_dat_o[2:0]))
    else $error("status state field not one hot");
  chk_ctrl_mirror: assert property (
    rd && wb_adr_i == slw_pkg::CTRL_OFS |-> wb_dat_o == {23'h0, ctrl_q})
    else $error("control read differs from last write");
  chk_pin_status: assert property (
    rd && wb_adr_i == slw_pkg::STATUS_OFS && pin_st_q == 3'h7
    |-> wb_dat_o[slw_pkg::ST_PIN_BIT] == manual_stopwatch_pin)
    else $error("status pin bit differs from settled pin");
  chk_never_started: assert property (
    rd && wb_adr_i == slw_pkg::RESULT_OFS && !seen_q |-> wb_dat_o == 32'h0)
    else $error("result nonzero before any start");
endmodule

bind slw_stopwatch slw_stopwatch_chk u_slw_stopwatch_chk (.clk(clk),
  .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .start_pt_a(start_pt_a), .start_pt_b(start_pt_b), .stop_pt_a(stop_pt_a),
  .stop_pt_b(stop_pt_b), .bit_tick(bit_tick),
  .manual_stopwatch_pin(manual_stopwatch_pin));

// >>> test_serdes_latency_stopwatch.sv
`timescale 1ns/10ps
module test_serdes_latency_stopwatch;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic pin = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] wb_dat_o;
  logic [31:0] v;
  logic wb_ack_o;
  logic tick;
  slw_pkg::slw_sym_s sa, sb, pa, pb;
  int bad_count = 0;
  int tests_run = 0;
  int exp_q[$];
  logic [7:0] cm[3] = '{slw_pkg::K28_1, slw_pkg::K28_5, slw_pkg::K28_7};

  slw_stopwatch u_slw_stopwatch (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .start_pt_a(sa), .start_pt_b(sb), .stop_pt_a(pa), .stop_pt_b(pb),
    .bit_tick(tick), .manual_stopwatch_pin(pin));
  slw_far_model u_slw_far_model (.clk(clk), .start_a(sa), .start_b(sb),
    .stop_a(pa), .stop_b(pb), .bit_tick(tick));

  // Free running clock
  initial forever #5 clk = ~clk;

  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Classic single bus cycle, waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 40);
    if (n >= 40) begin
      bad_count++;
      stop_test();
    end
    rdat = wb_dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask

  // One timed run against the model; p is clocks per count
  task automatic measure(input logic [8:0] c, input int p, input bit extra);
    int n;
    int e;
    logic [7:0] k;
    n = p * (5 + $urandom_range(30));
    k = cm[$urandom_range(2)];
    wb(1'h1, slw_pkg::CTRL_OFS, {23'h0, c});
    u_slw_far_model.send(1 - c[0], k);
    if (c[2]) pin <= 1'h1;
    else u_slw_far_model.send(c[0], k);
    repeat (n / 2 - 3) @(posedge clk);
    wb(1'h0, slw_pkg::STATUS_OFS, 32'h0);
    check("status_run", rdat[3:0], c[2] ? 32'ha : 32'h2);
    u_slw_far_model.send(c[0], cm[0]);
    u_slw_far_model.send(3 - c[1], k);
    repeat (n - n / 2) @(posedge clk);
    if (c[2]) pin <= 1'h0;
    else u_slw_far_model.send(2 + c[1], k);
    exp_q.push_back((n + 3 - c[2] + p / 2) / p);
    if (extra) begin
      u_slw_far_model.send(c[0], k);
      u_slw_far_model.send(2 + c[1], k);
    end
    repeat (8) @(posedge clk);
    wb(1'h0, slw_pkg::STATUS_OFS, 32'h0);
    check("status_hold", rdat[2:0], 32'h4);
    wb(1'h0, slw_pkg::RESULT_OFS, 32'h0);
    e = exp_q.pop_front();
    check("result", (rdat >= e - 1 && rdat <= e + 1) ? e : rdat, e);
    wb(1'h0, slw_pkg::RESULT_OFS, 32'h0);
    check("result_reread", rdat, 32'h0);
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h0000_59b1));
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    wb(1'h0, slw_pkg::CTRL_OFS, 32'h0);
    check("ctrl_reset", rdat, {23'h0, slw_pkg::CTRL_RST});
    wb(1'h0, slw_pkg::STATUS_OFS, 32'h0);
    check("status_reset", rdat, 32'h1);
    u_slw_far_model.send(2, slw_pkg::K28_5);
    wb(1'h1, slw_pkg::RESULT_OFS, $urandom);
    wb(1'h0, slw_pkg::RESULT_OFS, 32'h0);
    check("result_unstarted", rdat, 32'h0);
    wb(1'h1, 8'h0c, $urandom);
    wb(1'h0, 8'h0c, 32'h0);
    check("unmapped", rdat, 32'h0);
    v = $urandom;
    wb(1'h1, slw_pkg::CTRL_OFS, v);
    wb(1'h0, slw_pkg::CTRL_OFS, 32'h0);
    check("ctrl_rw", rdat, {23'h0, v[8:0]});
    for (int i = 0; i < 4; i++) begin
      measure({1'h1, 2'(i ^ 1), 2'(i), 2'h0, 2'($urandom)},
        (8 >> i) << (i ^ 1), i[0]);
    end
    u_slw_far_model.gap = 2;
    measure({7'h42, 2'($urandom)}, 40, 1'h1);
    measure({7'h41, 2'($urandom)}, 16, 1'h0);
    stop_test();
  end
endmodule
